// >>> design/humidity_aux_cool_pkg.sv
// constants, register map and carrier types for the humidity and auxiliary cooling sequencer
`default_nettype none
package humidity_aux_cool_pkg;
   // apb byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TEMP_LIM = 8'h04;
   localparam logic [7:0] OFS_DEW_LIM = 8'h08;
   localparam logic [7:0] OFS_SETPOINT = 8'h0c;
   localparam logic [7:0] OFS_PCT_CFG = 8'h10;
   localparam logic [7:0] OFS_DELAY_CFG = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_RH_LIMITS = 8'h1c;
   localparam logic [7:0] OFS_ALARM = 8'h20;
   localparam logic [7:0] OFS_WET_COIL = 8'h24;
   // control register fields
   localparam int CTRL_HUMID_EVENT = 0;
   localparam int CTRL_AUX_EVENT = 1;
   localparam int CTRL_ALTITUDE_ON = 2;
   localparam int CTRL_SINGLE_STAGE = 3;
   localparam int CTRL_LOW_RH_FITTED = 4;
   localparam int CTRL_AUX_CONTROL = 5;
   localparam int CTRL_HUMID_CFG_EN = 6;
   localparam int CTRL_WIDTH = 7;
   localparam int ALARM_SILENCE = 0;
   // reset values, temperatures in 0.1 degC, humidity in 0.1 %rh
   localparam logic [CTRL_WIDTH-1:0] CTRL_RST = 7'h00;
   localparam logic [31:0] TEMP_LIM_RST = 32'h03e8_0000;
   localparam logic [31:0] DEW_LIM_RST = 32'h0352_ffce;
   localparam logic [31:0] SETPOINT_RST = 32'h00fa_01f4;
   localparam logic [31:0] PCT_CFG_RST = 32'hfe0c_5a5a;
   localparam logic [31:0] DELAY_CFG_RST = 32'h0bb8_0bb8;
   localparam logic [15:0] WET_COIL_RST = 16'h0014;
   // psychrometric approximation: dewpoint = t - (full - rh) / slope
   localparam int RH_FULL = 1000;
   localparam int DEW_SLOPE = 5;
   localparam logic signed [15:0] FROZEN_ENTRY_DEW = 16'sh0064;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int FILL_DELAY_MIN = 30;
   localparam int FILL_DELAY_TICKS = FILL_DELAY_MIN * 60 * 1000 / TICK_MS;

   typedef enum logic [1:0] {
      HUM_OFF = 2'b00,
      HUM_WET = 2'b01,
      HUM_FROZEN = 2'b11
   } hum_state_t;

   typedef struct packed {
      logic signed [15:0] air_temp;
      logic signed [15:0] dewpoint;
      logic [7:0] humidify_pct;
      logic [7:0] cool_pct;
      logic level_ok;
   } meas_t;

   typedef struct packed {
      logic rh_limit_high;
      logic rh_limit_low;
      logic humidity_temp_disable_flag;
      logic chamber_shutdown;
      logic low_water_alarm;
      logic refrig_shutdown;
      logic aux_cool_control_out;
      logic boost_cool_out;
      logic aux_cool_supply_valve_out;
      logic frozen_coil_bypass_out;
      logic frozen_coil_control_out;
      logic max_humidify_out;
      logic dehumidify_enable_out;
      logic stage2_inhibit;
      logic rh_cool_reroute_out;
      logic humidity_supply_out;
   } outs_t;
endpackage
`default_nettype wire

// >>> design/humidity_aux_cool_sequencer.sv
// humidity and auxiliary cooling output sequencer with apb register file
`timescale 1ns/1ps
`default_nettype none
module humidity_aux_cool_sequencer #(
   parameter int unsigned TICK_CYCLES = humidity_aux_cool_pkg::TICK_CYCLES,
   parameter int unsigned FILL_DELAY_TICKS = humidity_aux_cool_pkg::FILL_DELAY_TICKS
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire humidity_aux_cool_pkg::meas_t i_meas,
   output humidity_aux_cool_pkg::outs_t o_outs
);
   logic [humidity_aux_cool_pkg::CTRL_WIDTH-1:0] ctrl;
   logic [31:0] temp_lim;
   logic [31:0] dew_lim;
   logic [31:0] setpoint;
   logic [31:0] pct_cfg;
   logic [31:0] delay_cfg;
   logic [15:0] wet_coil;
   humidity_aux_cool_pkg::hum_state_t state;
   humidity_aux_cool_pkg::hum_state_t next_state;
   humidity_aux_cool_pkg::outs_t next_outs;
   logic [15:0] tick_cnt;
   logic [20:0] fill_cnt;
   logic [15:0] hum_dly;
   logic [15:0] aux_dly;
   logic level_made;
   logic alarm;

   function automatic logic [15:0] rh_from_dew(input logic signed [15:0] t,
                                               input logic signed [15:0] dp);
      int v;
      v = humidity_aux_cool_pkg::RH_FULL - humidity_aux_cool_pkg::DEW_SLOPE * (int'(t) - int'(dp));
      if (v < 0) begin
         v = 0;
      end
      if (v > humidity_aux_cool_pkg::RH_FULL) begin
         v = humidity_aux_cool_pkg::RH_FULL;
      end
      return v[15:0];
   endfunction

   function automatic logic signed [15:0] dew_from_rh(input logic signed [15:0] t,
                                                      input logic [15:0] rh);
      int v;
      v = int'(t) - (humidity_aux_cool_pkg::RH_FULL - int'(rh)) / humidity_aux_cool_pkg::DEW_SLOPE;
      return v[15:0];
   endfunction

   // apb decode, zero wait states; prdata is loaded in the setup cycle
   wire setup = i_psel && !i_penable;
   wire access = i_psel && i_penable;
   wire hit = (i_paddr == humidity_aux_cool_pkg::OFS_CTRL) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_TEMP_LIM) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_DEW_LIM) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_SETPOINT) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_PCT_CFG) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_DELAY_CFG) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_STATUS) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_RH_LIMITS) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_ALARM) ||
              (i_paddr == humidity_aux_cool_pkg::OFS_WET_COIL);
   wire wr = access && i_pwrite && hit;
   wire silence = wr && (i_paddr == humidity_aux_cool_pkg::OFS_ALARM) &&
                  i_pwdata[humidity_aux_cool_pkg::ALARM_SILENCE];
   assign o_pready = 1'b1;
   assign o_pslverr = access && !hit;

   // configuration fields
   wire humid_event = ctrl[humidity_aux_cool_pkg::CTRL_HUMID_EVENT];
   wire aux_event = ctrl[humidity_aux_cool_pkg::CTRL_AUX_EVENT];
   wire altitude_on = ctrl[humidity_aux_cool_pkg::CTRL_ALTITUDE_ON];
   wire single_stage = ctrl[humidity_aux_cool_pkg::CTRL_SINGLE_STAGE];
   wire low_rh_fitted = ctrl[humidity_aux_cool_pkg::CTRL_LOW_RH_FITTED];
   wire aux_control = ctrl[humidity_aux_cool_pkg::CTRL_AUX_CONTROL];
   wire humid_cfg_en = ctrl[humidity_aux_cool_pkg::CTRL_HUMID_CFG_EN];
   wire signed [15:0] temp_min = temp_lim[15:0];
   wire signed [15:0] temp_max = temp_lim[31:16];
   wire signed [15:0] dew_min = dew_lim[15:0];
   wire signed [15:0] dew_max = dew_lim[31:16];
   wire [15:0] rh_sp = setpoint[15:0];
   wire signed [15:0] temp_sp = setpoint[31:16];
   wire [7:0] humid_on_pct = pct_cfg[7:0];
   wire [7:0] aux_on_pct = pct_cfg[15:8];
   wire signed [15:0] boost_low = pct_cfg[31:16];
   wire signed [15:0] wet_coil_min = wet_coil;

   // humidity enable chain
   wire humid_req = humid_event && humid_cfg_en && !altitude_on;
   wire temp_ok = (i_meas.air_temp >= temp_min) && (i_meas.air_temp <= temp_max);
   wire temp_block = humid_req && !temp_ok;
   wire humid_run = humid_req && temp_ok && !alarm;

   // setpoint coercion at present chamber temperature
   wire [15:0] rh_min = rh_from_dew(i_meas.air_temp, dew_min);
   wire [15:0] rh_max = rh_from_dew(i_meas.air_temp, dew_max);
   wire lim_low = rh_sp < rh_min;
   wire lim_high = rh_sp > rh_max;
   wire [15:0] rh_eff = lim_low ? rh_min : (lim_high ? rh_max : rh_sp);

   // frozen coil selection from the setpoint dewpoint
   wire signed [15:0] sp_dew = dew_from_rh(temp_sp, rh_eff);
   wire want_frozen = low_rh_fitted && (sp_dew < wet_coil_min);
   // holding off protects coil capacity from premature moisture loading
   wire frozen_ok = i_meas.dewpoint < humidity_aux_cool_pkg::FROZEN_ENTRY_DEW;

   always_comb begin
      case (state)
         humidity_aux_cool_pkg::HUM_OFF: begin
            next_state = humid_run ? humidity_aux_cool_pkg::HUM_WET : humidity_aux_cool_pkg::HUM_OFF;
         end
         humidity_aux_cool_pkg::HUM_WET: begin
            if (!humid_run) begin
               next_state = humidity_aux_cool_pkg::HUM_OFF;
            end else if (want_frozen && frozen_ok) begin
               next_state = humidity_aux_cool_pkg::HUM_FROZEN;
            end else begin
               next_state = humidity_aux_cool_pkg::HUM_WET;
            end
         end
         humidity_aux_cool_pkg::HUM_FROZEN: begin
            if (!humid_run) begin
               next_state = humidity_aux_cool_pkg::HUM_OFF;
            end else if (!want_frozen) begin
               next_state = humidity_aux_cool_pkg::HUM_WET;
            end else begin
               next_state = humidity_aux_cool_pkg::HUM_FROZEN;
            end
         end
         default: begin
            next_state = humidity_aux_cool_pkg::HUM_OFF;
         end
      endcase
   end

   // 1 ms tick shared by all delay timers
   wire tick = tick_cnt == 16'(TICK_CYCLES - 1);
   wire fill_expired = fill_cnt == 21'(FILL_DELAY_TICKS);
   wire hum_above = i_meas.humidify_pct > humid_on_pct;
   wire aux_above = i_meas.cool_pct > aux_on_pct;
   wire hum_done = hum_dly == delay_cfg[15:0];
   wire aux_done = aux_dly == delay_cfg[31:16];

   // low-water detection; level loss after fill beats the fill timer
   wire low_water_event = humid_req && !alarm &&
                          ((fill_expired && !level_made) ||
                           (level_made && !i_meas.level_ok));

   // auxiliary cooling
   wire aux_req = aux_event && !altitude_on;
   wire at_low = i_meas.air_temp <= boost_low;
   wire hum_on = state != humidity_aux_cool_pkg::HUM_OFF;

   always_comb begin
      next_outs = '0;
      next_outs.humidity_supply_out = hum_on;
      next_outs.rh_cool_reroute_out = hum_on && single_stage;
      next_outs.stage2_inhibit = hum_on && single_stage;
      next_outs.dehumidify_enable_out = state == humidity_aux_cool_pkg::HUM_WET;
      next_outs.max_humidify_out = hum_on && hum_above && hum_done;
      next_outs.frozen_coil_control_out = state == humidity_aux_cool_pkg::HUM_FROZEN;
      next_outs.frozen_coil_bypass_out = state == humidity_aux_cool_pkg::HUM_FROZEN;
      next_outs.aux_cool_supply_valve_out = aux_req;
      next_outs.boost_cool_out = aux_req && aux_above && aux_done && !at_low;
      next_outs.aux_cool_control_out = aux_req && aux_control && at_low;
      next_outs.refrig_shutdown = aux_req && aux_control && at_low;
      next_outs.low_water_alarm = alarm;
      next_outs.chamber_shutdown = alarm;
      next_outs.humidity_temp_disable_flag = temp_block;
      next_outs.rh_limit_low = lim_low;
      next_outs.rh_limit_high = lim_high;
   end

   // register writes
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl <= humidity_aux_cool_pkg::CTRL_RST;
         temp_lim <= humidity_aux_cool_pkg::TEMP_LIM_RST;
         dew_lim <= humidity_aux_cool_pkg::DEW_LIM_RST;
         setpoint <= humidity_aux_cool_pkg::SETPOINT_RST;
         pct_cfg <= humidity_aux_cool_pkg::PCT_CFG_RST;
         delay_cfg <= humidity_aux_cool_pkg::DELAY_CFG_RST;
         wet_coil <= humidity_aux_cool_pkg::WET_COIL_RST;
      end else if (wr) begin
         case (i_paddr)
            humidity_aux_cool_pkg::OFS_CTRL: ctrl <= i_pwdata[humidity_aux_cool_pkg::CTRL_WIDTH-1:0];
            humidity_aux_cool_pkg::OFS_TEMP_LIM: temp_lim <= i_pwdata;
            humidity_aux_cool_pkg::OFS_DEW_LIM: dew_lim <= i_pwdata;
            humidity_aux_cool_pkg::OFS_SETPOINT: setpoint <= i_pwdata;
            humidity_aux_cool_pkg::OFS_PCT_CFG: pct_cfg <= i_pwdata;
            humidity_aux_cool_pkg::OFS_DELAY_CFG: delay_cfg <= i_pwdata;
            humidity_aux_cool_pkg::OFS_WET_COIL: wet_coil <= i_pwdata[15:0];
            default: ctrl <= ctrl;
         endcase
      end
   end

   // read data
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prdata <= 32'h0;
      end else if (setup) begin
         case (i_paddr)
            humidity_aux_cool_pkg::OFS_CTRL: o_prdata <= {25'h0, ctrl};
            humidity_aux_cool_pkg::OFS_TEMP_LIM: o_prdata <= temp_lim;
            humidity_aux_cool_pkg::OFS_DEW_LIM: o_prdata <= dew_lim;
            humidity_aux_cool_pkg::OFS_SETPOINT: o_prdata <= setpoint;
            humidity_aux_cool_pkg::OFS_PCT_CFG: o_prdata <= pct_cfg;
            humidity_aux_cool_pkg::OFS_DELAY_CFG: o_prdata <= delay_cfg;
            humidity_aux_cool_pkg::OFS_STATUS: o_prdata <= {14'h0, state, o_outs};
            humidity_aux_cool_pkg::OFS_RH_LIMITS: o_prdata <= {rh_max, rh_min};
            humidity_aux_cool_pkg::OFS_ALARM: o_prdata <= {31'h0, alarm};
            humidity_aux_cool_pkg::OFS_WET_COIL: o_prdata <= {16'h0, wet_coil};
            default: o_prdata <= 32'h0;
         endcase
      end
   end

   // state, alarm and outputs
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= humidity_aux_cool_pkg::HUM_OFF;
         alarm <= 1'b0;
         o_outs <= '0;
      end else begin
         state <= next_state;
         o_outs <= next_outs;
         // a new low-water event wins over a silence in the same cycle
         if (low_water_event) begin
            alarm <= 1'b1;
         end else if (silence) begin
            alarm <= 1'b0;
         end
      end
   end

   // fill delay masks the level input until the boiler has had time to fill
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tick_cnt <= 16'h0;
         fill_cnt <= 21'h0;
         level_made <= 1'b0;
      end else begin
         tick_cnt <= tick ? 16'h0 : tick_cnt + 16'h1;
         if (!humid_req || silence) begin
            fill_cnt <= 21'h0;
            level_made <= 1'b0;
         end else begin
            if (tick && !fill_expired && !level_made && !alarm) begin
               fill_cnt <= fill_cnt + 21'h1;
            end
            if (i_meas.level_ok) begin
               level_made <= 1'b1;
            end
         end
      end
   end

   // on-delay timers, saturate at the configured delay
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hum_dly <= 16'h0;
         aux_dly <= 16'h0;
      end else begin
         if (!hum_above || !hum_on) begin
            hum_dly <= 16'h0;
         end else if (tick && !hum_done) begin
            hum_dly <= hum_dly + 16'h1;
         end
         if (!aux_above || !aux_req) begin
            aux_dly <= 16'h0;
         end else if (tick && !aux_done) begin
            aux_dly <= aux_dly + 16'h1;
         end
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);

   chk_supply_on: assert property (hum_on |=> o_outs.humidity_supply_out)
      else $error("humidity supply not asserted while humidity on");
   chk_reroute_stage2: assert property (hum_on && single_stage |=>
      o_outs.rh_cool_reroute_out && o_outs.stage2_inhibit)
      else $error("reroute or compressor inhibit missing");
   chk_wet_dehum: assert property (state == humidity_aux_cool_pkg::HUM_WET |=>
      o_outs.dehumidify_enable_out && !o_outs.frozen_coil_control_out)
      else $error("dehumidify enable wrong in wet mode");
   chk_max_hum_delay: assert property (o_outs.max_humidify_out |->
      $past(hum_above) && $past(hum_dly) == $past(delay_cfg[15:0]))
      else $error("maximum humidify before on-delay");
   chk_fill_expire: assert property (humid_req && fill_expired && !level_made && !alarm |=>
      alarm ##1 o_outs.chamber_shutdown)
      else $error("fill delay expiry did not raise alarm");
   chk_level_loss: assert property (humid_req && level_made && !i_meas.level_ok && !alarm
      |=> alarm)
      else $error("level loss did not alarm at once");
   chk_silence_restart: assert property (silence && !low_water_event |=>
      !alarm && fill_cnt == 21'h0)
      else $error("silence did not restart fill delay");
   chk_temp_block: assert property (temp_block |=> state == humidity_aux_cool_pkg::HUM_OFF
      && o_outs.humidity_temp_disable_flag)
      else $error("temperature block did not stop humidity");
   chk_frozen_entry: assert property ($rose(o_outs.frozen_coil_control_out) |->
      $past(i_meas.dewpoint, 2) < humidity_aux_cool_pkg::FROZEN_ENTRY_DEW)
      else $error("frozen coil entered above dewpoint threshold");
   chk_frozen_outs: assert property (state == humidity_aux_cool_pkg::HUM_FROZEN |=>
      o_outs.frozen_coil_control_out && o_outs.frozen_coil_bypass_out &&
      !o_outs.dehumidify_enable_out)
      else $error("frozen coil outputs wrong");
   chk_boost_low: assert property (at_low |=> !o_outs.boost_cool_out)
      else $error("boost cooling on at low limit");
   chk_altitude_hold: assert property (altitude_on |=> state == humidity_aux_cool_pkg::HUM_OFF
      && !o_outs.aux_cool_supply_valve_out ##1 !o_outs.humidity_supply_out)
      else $error("altitude did not disable humidity or aux cooling");
   chk_hum_off_clear: assert property (state == humidity_aux_cool_pkg::HUM_OFF |=>
      o_outs[6:0] == 7'h0)
      else $error("humidity outputs left on while off");
   chk_delay_restart: assert property (!hum_above |=> hum_dly == 16'h0)
      else $error("on-delay timer not restarted");
   chk_valve_event: assert property (aux_req |=> o_outs.aux_cool_supply_valve_out)
      else $error("supply valve off while aux event on");
   chk_boost_delay: assert property (o_outs.boost_cool_out |->
      $past(aux_above) && $past(aux_dly) == $past(delay_cfg[31:16]))
      else $error("boost cooling before on-delay");
   chk_boost_drop: assert property (aux_req && !aux_above |=>
      !o_outs.boost_cool_out && o_outs.aux_cool_supply_valve_out)
      else $error("boost not dropped or valve lost");
   chk_control_boost: assert property (!at_low |=>
      !o_outs.aux_cool_control_out && !o_outs.refrig_shutdown)
      else $error("aux control active above low limit");
   chk_aux_control: assert property (aux_req && aux_control && at_low |=>
      o_outs.aux_cool_control_out && o_outs.refrig_shutdown)
      else $error("aux control not taken at low limit");
   chk_aux_off: assert property (!aux_req |=> o_outs[10:7] == 4'h0)
      else $error("aux cooling outputs on without request");
   chk_temp_restart: assert property (state == humidity_aux_cool_pkg::HUM_OFF && humid_run |=>
      state == humidity_aux_cool_pkg::HUM_WET)
      else $error("humidity did not restart");
   chk_temp_flag: assert property (o_outs.humidity_temp_disable_flag |->
      state == humidity_aux_cool_pkg::HUM_OFF)
      else $error("disable flag shown while humidity runs");
   chk_level_masked: assert property (humid_req && !level_made && !fill_expired && !alarm |=>
      !alarm)
      else $error("low-water alarm during fill delay");
   chk_fill_hold: assert property (alarm |=> $stable(fill_cnt) || fill_cnt == 21'h0)
      else $error("fill delay ran during alarm");
   chk_alarm_shutdown: assert property (alarm |=> state == humidity_aux_cool_pkg::HUM_OFF &&
      o_outs.chamber_shutdown && o_outs.low_water_alarm)
      else $error("alarm did not shut chamber down");
   chk_single_off: assert property (!single_stage |=>
      !o_outs.rh_cool_reroute_out && !o_outs.stage2_inhibit)
      else $error("reroute on without single stage");
   chk_frozen_exit: assert property (state == humidity_aux_cool_pkg::HUM_FROZEN && humid_run &&
      !want_frozen |=> state == humidity_aux_cool_pkg::HUM_WET)
      else $error("frozen coil held without demand");
   chk_max_hum_drop: assert property (!hum_above |=> !o_outs.max_humidify_out)
      else $error("maximum humidify on below setpoint");

   cov_frozen: cover property (state == humidity_aux_cool_pkg::HUM_FROZEN);
   cov_boost: cover property (o_outs.boost_cool_out);
   cov_alarm: cover property (alarm ##1 silence);
   cov_control: cover property (o_outs.aux_cool_control_out);
   cov_temp_block: cover property (o_outs.humidity_temp_disable_flag);
endmodule // humidity_aux_cool_sequencer
`default_nettype wire

// >>> testbench/humidity_chamber_model.sv
// boiler and measurement stand-in for the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module humidity_chamber_model (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_fill,
   input wire humidity_aux_cool_pkg::outs_t i_outs,
   input wire humidity_aux_cool_pkg::meas_t i_stim,
   output humidity_aux_cool_pkg::meas_t o_meas
);
   logic [2:0] fill_cnt;
   // level made only after the feed has run a while; a cut feed drops it at once
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst)
         fill_cnt <= 3'h0;
      else if (!i_fill)
         fill_cnt <= 3'h0;
      else if (i_outs.humidity_supply_out && fill_cnt != 3'h7)
         fill_cnt <= fill_cnt + 3'h1;
   end
   always_comb begin
      o_meas = i_stim;
      o_meas.level_ok = (fill_cnt == 3'h7);
   end
endmodule // humidity_chamber_model
`default_nettype wire

// >>> testbench/humidity_aux_cool_sequencer_tb.sv
// self-checking bench for the humidity and auxiliary cooling sequencer
`timescale 1ns/1ps
`default_nettype none
module humidity_aux_cool_sequencer_tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, fill, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   humidity_aux_cool_pkg::meas_t stim, meas;
   humidity_aux_cool_pkg::outs_t o;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   humidity_aux_cool_sequencer #(.TICK_CYCLES(4), .FILL_DELAY_TICKS(10)) u_dut (
      .i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_meas(meas), .o_outs(o));
   humidity_chamber_model u_model (.i_clk_sys(clk), .i_sys_rst(rst), .i_fill(fill),
      .i_outs(o), .i_stim(stim), .o_meas(meas));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // master holds the whole request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setm(input logic [15:0] t, d, input logic [7:0] h, c, input logic f);
      @(posedge clk);
      stim <= '{air_temp: t, dewpoint: d, humidify_pct: h, cool_pct: c, level_ok: 1'b0};
      fill <= f;
   endtask
   // outputs are flops, so look at them mid-cycle
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      fill = 1'b0;
      stim = '{16'h00fa, 16'h00c8, 8'h00, 8'h00, 1'b0};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wt(1);
      cmp("outs after reset", 32'h0, {16'h0, o});
      apb(1'b0, 8'h00, 32'h0);
      cmp("ctrl reset", 32'h0, rd);
      apb(1'b0, 8'h28, 32'h0);
      cmp("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      setm(16'h00fa, 16'h00c8, 8'h00, 8'h00, 1'b1);
      apb(1'b1, 8'h14, 32'h0002_0002);
      apb(1'b1, 8'h00, 32'h49);
      wt(3);
      cmp("humidity outs", 32'hf, {28'h0, o[3:0]});
      setm(16'h00fa, 16'h00c8, 8'd95, 8'h00, 1'b1);
      wt(4);
      cmp("max humidify early", 32'h0, {31'h0, o.max_humidify_out});
      wt(12);
      cmp("max humidify", 32'h1, {31'h0, o.max_humidify_out});
      setm(16'h00fa, 16'h00c8, 8'd50, 8'h00, 1'b0);
      wt(4);
      cmp("level loss alarm", 32'h6, {29'h0, o[12:11], o[0]});
      apb(1'b1, 8'h20, 32'h1);
      wt(24);
      cmp("silence resumes", 32'h1, {29'h0, o[12:11], o[0]});
      wt(40);
      cmp("fill expired", 32'h6, {29'h0, o[12:11], o[0]});
      setm(16'h00fa, 16'h00c8, 8'd50, 8'h00, 1'b1);
      apb(1'b1, 8'h20, 32'h1);
      setm(16'h044c, 16'h00c8, 8'd50, 8'h00, 1'b1);
      wt(4);
      cmp("temp disable", 32'h2, {30'h0, o.humidity_temp_disable_flag, o[0]});
      setm(16'h00fa, 16'h00c8, 8'd50, 8'h00, 1'b1);
      wt(4);
      cmp("temp restart", 32'h1, {30'h0, o.humidity_temp_disable_flag, o[0]});
      $display("test humidity done");
      apb(1'b1, 8'h08, 32'h00c8_0096);
      apb(1'b1, 8'h0c, 32'h00fa_0384);
      wt(4);
      apb(1'b0, 8'h1c, 32'h0);
      cmp("rh limits", 32'h02ee_01f4, rd);
      cmp("limit high", 32'h2, {30'h0, o[15:14]});
      apb(1'b1, 8'h0c, 32'h00fa_0064);
      wt(4);
      cmp("limit low", 32'h1, {30'h0, o[15:14]});
      apb(1'b1, 8'h08, 32'h0352_ffce);
      apb(1'b1, 8'h0c, 32'h0064_0000);
      apb(1'b1, 8'h00, 32'h51);
      wt(4);
      cmp("frozen held off", 32'h1, {29'h0, o[6:5], o[3]});
      setm(16'h00fa, 16'h0032, 8'd50, 8'h00, 1'b1);
      wt(4);
      cmp("frozen coil", 32'h6, {29'h0, o[6:5], o[3]});
      apb(1'b0, 8'h18, 32'h0);
      cmp("status frozen", 32'h0003_0061, rd);
      apb(1'b1, 8'h00, 32'h57);
      wt(4);
      cmp("altitude", 32'h0, {22'h0, o[9:0]});
      $display("test frozen and altitude done");
      apb(1'b1, 8'h00, 32'h02);
      setm(16'h00fa, 16'h0032, 8'd50, 8'd95, 1'b1);
      wt(4);
      cmp("valve boost early", 32'h1, {30'h0, o[8:7]});
      wt(12);
      cmp("boost on", 32'h3, {30'h0, o[8:7]});
      setm(16'h00fa, 16'h0032, 8'd50, 8'd50, 1'b1);
      wt(4);
      cmp("boost off", 32'h1, {30'h0, o[8:7]});
      setm(16'h00fa, 16'h0032, 8'd50, 8'd95, 1'b1);
      wt(3);
      setm(16'h00fa, 16'h0032, 8'd50, 8'd50, 1'b1);
      wt(1);
      setm(16'h00fa, 16'h0032, 8'd50, 8'd95, 1'b1);
      wt(4);
      cmp("boost delay restart", 32'h1, {30'h0, o[8:7]});
      setm(16'hfda8, 16'h0032, 8'd50, 8'd95, 1'b1);
      wt(16);
      cmp("boost low limit", 32'h1, {30'h0, o[8:7]});
      apb(1'b1, 8'h00, 32'h22);
      wt(4);
      cmp("aux control", 32'h30, {26'h0, o[10:9], o[3:0]});
      setm(16'h00fa, 16'h0032, 8'd50, 8'd95, 1'b1);
      wt(16);
      cmp("control as boost", 32'h1, {29'h0, o[10:9], o[8]});
      $display("test aux cooling done");
      end_sim();
   end
endmodule // humidity_aux_cool_sequencer_tb
`default_nettype wire
